// file: src/tpi_map.svh
// register offsets, field positions, reset values and decode constants
`ifndef TPI_MAP_SVH
`define TPI_MAP_SVH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define TPI_REG_CTRL 8'h00
`define TPI_REG_STATUS 8'h04
`define TPI_REG_COUNT 8'h08
`define TPI_CTRL_OPCLR 0
`define TPI_CTRL_EOTCLR 1
`define TPI_CTRL_LANE_LO 4
`define TPI_ST_CAUSE_LO 8
`define TPI_ST_EOT 12
`define TPI_ST_BUSY 13
`define TPI_ST_HALT 14
`define TPI_LANE_RST 4'h0
`define TPI_RESP_OKAY 2'b00
`define TPI_RESP_SLVERR 2'b10
// ----------------------------------------------------------------
// instruction decode
// ----------------------------------------------------------------
`define TPI_OP_POSITION 8'h58
`define TPI_BLKLEN_LO 8'h02
`define TPI_BLKLEN_HI 8'h09
`define TPI_VAR_BWD 4'h1
`define TPI_VAR_END 4'h2
`define TPI_VAR_EOT 4'h1
`define TPI_ZERO_COUNT 4'ha
// ----------------------------------------------------------------
// tape pin positions in the synchroniser vector
// ----------------------------------------------------------------
`define TPI_NPIN 9
`define TPI_PIN_READY 0
`define TPI_PIN_RING 1
`define TPI_PIN_PREFACE 2
`define TPI_PIN_BLANK 3
`define TPI_PIN_EOTBLK 4
`define TPI_PIN_MISMATCH 5
`define TPI_PIN_WRITTEN 6
`define TPI_PIN_EOTMARK 7
`define TPI_PIN_BOTMARK 8
`endif

// file: src/tpi_pkg.sv
// shared types of the tape positioning and interrogate block
package tpi_pkg;
  // controller states, one-hot
  typedef enum logic [7:0] {
    TPI_IDLE = 8'h01,
    TPI_OVW = 8'h02,
    TPI_POS_F = 8'h04,
    TPI_POS_B = 8'h08,
    TPI_END_F = 8'h10,
    TPI_END_B = 8'h20,
    TPI_HUNG = 8'h40,
    TPI_ALARM = 8'h80
  } tpi_state_e;
  // alarm stop causes kept for the operator
  typedef enum logic [3:0] {
    TPI_CAUSE_NONE = 4'h0,
    TPI_CAUSE_BLKLEN = 4'h1,
    TPI_CAUSE_NOTWRITE = 4'h2,
    TPI_CAUSE_NOTREADY = 4'h3,
    TPI_CAUSE_MISMATCH = 4'h4,
    TPI_CAUSE_EOT = 4'h5
  } tpi_cause_e;
endpackage

// file: src/tpi_axil.sv
// axi4-lite register slave feeding the tape controller
`timescale 1ns/1ps
`default_nettype none
`include "tpi_map.svh"
module tpi_axil (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // axi4-lite
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register side
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  typedef struct packed {
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awready;
    logic wready;
    logic arready;
  } tpi_axil_s;
  tpi_axil_s st, next_st;

  // write fires once both halves are held and no response is pending
  assign wr_en = st.aw_held & st.w_held & ~st.bvalid;
  assign wr_addr = st.awaddr;
  assign wr_data = st.wdata;
  assign wr_strb = st.wstrb;

  // channel handshakes; address and data may come in either order
  always_comb begin
    next_st = st;
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (wr_en) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = wr_err ? `TPI_RESP_SLVERR : `TPI_RESP_OKAY;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_data;
      next_st.rresp = rd_err ? `TPI_RESP_SLVERR : `TPI_RESP_OKAY;
    end
    // ready flags registered so the ports come from flops
    next_st.awready = ~next_st.aw_held & ~next_st.bvalid;
    next_st.wready = ~next_st.w_held & ~next_st.bvalid;
    next_st.arready = ~next_st.rvalid;
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bresp = st.bresp;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_arready = st.arready;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rvalid = st.rvalid;
endmodule
`default_nettype wire

// file: src/tpi_core.sv
// tape instruction execution: overwrite closing, positioning, interrogate
`timescale 1ns/1ps
`default_nettype none
`include "tpi_map.svh"
module tpi_core
  import tpi_pkg::*;
#(
  parameter logic [7:0] OVW_OP = 8'h01, // arbitrary op code
  parameter logic [7:0] IRG_OP = 8'h02, // arbitrary op code
  parameter int LW = 4
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // instruction sequencer
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [3:0] instr_sign,
  input wire logic [3:0] instr_unit,
  input wire logic [7:0] instr_d34,
  input wire logic [3:0] instr_count,
  input wire logic [3:0] instr_var,
  input wire logic [7:0] instr_op,
  input wire logic [15:0] instr_addr,
  input wire logic [15:0] b_reg,
  output logic done,
  output logic branch,
  output logic [15:0] branch_addr,
  output logic halt,
  // tape unit pins
  input wire logic unit_ready,
  input wire logic write_ring,
  input wire logic preface_seen,
  input wire logic blank_long,
  input wire logic eot_block,
  input wire logic preface_mismatch,
  input wire logic block_written,
  input wire logic eot_marker,
  input wire logic bot_marker,
  output logic [3:0] unit_sel,
  output logic [LW-1:0] lane,
  output logic move_fwd,
  output logic move_bwd,
  output logic write_en,
  // axi4-lite
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    tpi_state_e state;
    tpi_cause_e cause;
    logic [3:0] remaining;
    logic eot_ind;
    logic [LW-1:0] lane;
    logic [3:0] unit;
    logic [`TPI_NPIN-1:0] s1;
    logic [`TPI_NPIN-1:0] s2;
    logic [`TPI_NPIN-1:0] s3;
    logic instr_ready;
    logic done;
    logic branch;
    logic [15:0] branch_addr;
    logic halt;
    logic fwd;
    logic bwd;
    logic we;
  } tpi_core_s;
  tpi_core_s st, next_st;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // zero count stands for ten blocks
  function automatic logic [3:0] blocks(input logic [3:0] n);
    blocks = (n == 4'h0) ? `TPI_ZERO_COUNT : n;
  endfunction

  // effective address with optional index
  function automatic logic [15:0] eff_addr(input logic [3:0] sg,
      input logic [15:0] a, input logic [15:0] b);
    eff_addr = sg[0] ? 16'(a + b) : a;
  endfunction

  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic [31:0] rd_data;
  logic rd_err;
  logic [`TPI_NPIN-1:0] pins;
  logic [`TPI_NPIN-1:0] lvl;
  logic [`TPI_NPIN-1:0] ev;
  logic idle;
  logic take;
  logic is_irg;
  logic is_pos;
  logic is_ovw;
  logic bad_len;

  // pins gathered so one synchroniser chain serves them all
  assign pins = {bot_marker, eot_marker, block_written, preface_mismatch,
                 eot_block, blank_long, preface_seen, write_ring, unit_ready};
  // second stage is the first one logic may read
  assign lvl = st.s2;
  assign ev = st.s2 & ~st.s3;

  // ----------------------------------------------------------------
  // instruction acceptance
  // ----------------------------------------------------------------
  // interrogate is answered in every state but alarm; tape motion only starts from idle
  assign idle = (st.state == TPI_IDLE);
  assign is_irg = (instr_op == IRG_OP);
  assign is_pos = (instr_op == `TPI_OP_POSITION);
  assign is_ovw = (instr_op == OVW_OP);
  assign take = instr_valid & st.instr_ready & (is_irg | (idle & (is_pos | is_ovw)));
  assign bad_len = (instr_d34 >= `TPI_BLKLEN_LO) && (instr_d34 <= `TPI_BLKLEN_HI);

  // register read decode; unmapped words answer an error
  always_comb begin
    rd_data = 32'h0;
    rd_err = 1'b0;
    wr_err = ~((wr_addr == `TPI_REG_CTRL) | (wr_addr == `TPI_REG_STATUS)
               | (wr_addr == `TPI_REG_COUNT));
    unique case (s_axi_araddr)
      `TPI_REG_CTRL: rd_data[`TPI_CTRL_LANE_LO +: LW] = st.lane;
      `TPI_REG_STATUS: begin
        rd_data[7:0] = st.state;
        rd_data[`TPI_ST_CAUSE_LO +: 4] = st.cause;
        rd_data[`TPI_ST_EOT] = st.eot_ind;
        rd_data[`TPI_ST_BUSY] = ~idle;
        rd_data[`TPI_ST_HALT] = st.halt;
      end
      `TPI_REG_COUNT: rd_data[3:0] = st.remaining;
      default: rd_err = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.s1 = pins;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.done = 1'b0;
    next_st.branch = 1'b0;
    // software writes come first so a same-cycle hardware set wins
    if (wr_en && wr_strb[0] && wr_addr == `TPI_REG_CTRL) begin
      next_st.lane = wr_data[`TPI_CTRL_LANE_LO +: LW];
      if (wr_data[`TPI_CTRL_EOTCLR]) begin
        next_st.eot_ind = 1'b0;
      end
      // operator intervention releases a hung or stopped unit
      if (wr_data[`TPI_CTRL_OPCLR] && (st.state == TPI_HUNG || st.state == TPI_ALARM)) begin
        next_st.state = TPI_IDLE;
        next_st.cause = TPI_CAUSE_NONE;
        next_st.fwd = 1'b0;
        next_st.bwd = 1'b0;
        next_st.we = 1'b0;
      end
    end
    if (take) begin
      next_st.unit = instr_unit;
    end
    // interrogate never steals a cycle from the tape sequencing below
    if (take && is_irg) begin
      next_st.done = 1'b1;
      next_st.branch_addr = eff_addr(instr_sign, instr_addr, b_reg);
      if (instr_var == `TPI_VAR_EOT) begin
        next_st.branch = st.eot_ind;
      end else begin
        next_st.branch = idle & lvl[`TPI_PIN_READY];
      end
    end
    // tape ops start only from idle, where the case below has nothing to do
    if (take && !is_irg) begin
      if (is_pos) begin
        next_st.remaining = blocks(instr_count);
        if (instr_var == `TPI_VAR_BWD) begin
          next_st.state = TPI_POS_B;
          next_st.bwd = 1'b1;
        end else if (instr_var == `TPI_VAR_END) begin
          next_st.state = TPI_END_F;
          next_st.fwd = 1'b1;
        end else begin
          next_st.state = TPI_POS_F;
          next_st.fwd = 1'b1;
        end
      end else begin
        next_st.remaining = blocks(instr_count);
        // length check before any motion so the head stays where it was
        if (bad_len) begin
          next_st.state = TPI_ALARM;
          next_st.cause = TPI_CAUSE_BLKLEN;
        end else if (!lvl[`TPI_PIN_READY]) begin
          next_st.state = TPI_ALARM;
          next_st.cause = TPI_CAUSE_NOTREADY;
        end else if (!lvl[`TPI_PIN_RING]) begin
          next_st.state = TPI_ALARM;
          next_st.cause = TPI_CAUSE_NOTWRITE;
        end else begin
          next_st.state = TPI_OVW;
          next_st.fwd = 1'b1;
          next_st.we = 1'b1;
        end
      end
    end else begin
      unique case (st.state)
        // control blocks and blank tape raise no event here
        TPI_OVW: begin
          if (ev[`TPI_PIN_EOTMARK]) begin
            next_st.state = TPI_ALARM;
            next_st.cause = TPI_CAUSE_EOT;
          end else if (ev[`TPI_PIN_MISMATCH]) begin
            if (lvl[`TPI_PIN_EOTBLK]) begin
              next_st.state = TPI_IDLE;
              next_st.eot_ind = 1'b1;
              next_st.done = 1'b1;
            end else begin
              next_st.state = TPI_ALARM;
              next_st.cause = TPI_CAUSE_MISMATCH;
            end
          end else if (ev[`TPI_PIN_WRITTEN]) begin
            next_st.remaining = st.remaining - 4'h1;
            if (st.remaining == 4'h1) begin
              next_st.state = TPI_IDLE;
              next_st.done = 1'b1;
            end
          end
        end
        // any preface counts, whatever kind of block it heads
        TPI_POS_F, TPI_POS_B: begin
          if ((st.state == TPI_POS_F && ev[`TPI_PIN_EOTMARK])
              || (st.state == TPI_POS_B && ev[`TPI_PIN_BOTMARK])) begin
            next_st.state = TPI_HUNG;
          end else if (ev[`TPI_PIN_PREFACE]) begin
            next_st.remaining = st.remaining - 4'h1;
            if (st.remaining == 4'h1) begin
              next_st.state = TPI_IDLE;
              next_st.done = 1'b1;
            end
          end
        end
        TPI_END_F: begin
          if (ev[`TPI_PIN_EOTMARK]) begin
            next_st.state = TPI_ALARM;
            next_st.cause = TPI_CAUSE_EOT;
          end else if (ev[`TPI_PIN_BLANK]) begin
            next_st.state = TPI_END_B;
          end
        end
        TPI_END_B: begin
          if (ev[`TPI_PIN_PREFACE]) begin
            next_st.state = TPI_IDLE;
            next_st.done = 1'b1;
          end
        end
        TPI_IDLE, TPI_HUNG, TPI_ALARM: begin
        end
      endcase
    end
    // motion follows the state; hung and stopped units stand still
    next_st.fwd = next_st.state inside {TPI_OVW, TPI_POS_F, TPI_END_F};
    next_st.bwd = next_st.state inside {TPI_POS_B, TPI_END_B};
    next_st.we = (next_st.state == TPI_OVW);
    next_st.halt = (next_st.state == TPI_ALARM);
    next_st.instr_ready = (next_st.state != TPI_ALARM);
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{state: TPI_IDLE, cause: TPI_CAUSE_NONE, lane: `TPI_LANE_RST, default: '0};
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  tpi_axil u_axil (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  assign instr_ready = st.instr_ready;
  assign done = st.done;
  assign branch = st.branch;
  assign branch_addr = st.branch_addr;
  assign halt = st.halt;
  assign unit_sel = st.unit;
  assign lane = st.lane;
  assign move_fwd = st.fwd;
  assign move_bwd = st.bwd;
  assign write_en = st.we;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [15:0] mod_sum;
  logic rdy_now;
  assign mod_sum = 16'(instr_addr + b_reg);
  assign rdy_now = idle & lvl[`TPI_PIN_READY];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  blk_len_stop_a: assert property (ce && take && is_ovw && bad_len
      |=> st.state == TPI_ALARM && st.cause == TPI_CAUSE_BLKLEN && !move_fwd && !move_bwd)
    else $error("bad block length did not stop in place");
  not_write_a: assert property (ce && take && is_ovw && !bad_len && lvl[`TPI_PIN_READY]
      && !lvl[`TPI_PIN_RING] |=> st.state == TPI_ALARM && st.cause == TPI_CAUSE_NOTWRITE)
    else $error("missing write ring not stopped");
  pos_decode_a: assert property (ce && take && is_pos && instr_var != `TPI_VAR_BWD
      && instr_var != `TPI_VAR_END |=> st.state == TPI_POS_F && move_fwd && !move_bwd)
    else $error("odd variation did not run forward");
  count_ten_a: assert property (ce && take && is_pos && instr_count == 4'h0
      |=> st.remaining == 4'ha)
    else $error("zero count not taken as ten");
  eot_hang_a: assert property (ce && st.state == TPI_POS_F && ev[`TPI_PIN_EOTMARK]
      && !take |=> st.state == TPI_HUNG ##0 !done [*2])
    else $error("end marker gave completion");
  int_eot_a: assert property (ce && take && is_irg && instr_var == `TPI_VAR_EOT
      |=> done && branch == $past(st.eot_ind))
    else $error("end-of-tape branch wrong");
  rdy_both_a: assert property (ce && take && is_irg && instr_var != `TPI_VAR_EOT
      |=> branch == $past(rdy_now))
    else $error("ready branch wrong");
  addr_mod_a: assert property (ce && take && is_irg
      |=> branch_addr == ($past(instr_sign[0]) ? $past(mod_sum) : $past(instr_addr)))
    else $error("address modification wrong");
  alarm_halt_a: assert property (st.state == TPI_ALARM
      |-> halt && !instr_ready && st.cause != TPI_CAUSE_NONE && !move_fwd)
    else $error("alarm did not halt");
endmodule
`default_nettype wire

// file: test/tpi_tape_model.sv
// behavioural tape storage unit on the far side of the controller
`timescale 1ns/1ps
`default_nettype none
module tpi_tape_model (
  // bench knobs
  input wire logic clk,
  input wire logic [3:0] gap,
  input wire logic [7:0] eoi,
  input wire logic rdy, ring, eot_lvl, mism, mark,
  // controller side
  input wire logic move_fwd, move_bwd, write_en,
  output logic unit_ready, write_ring, eot_block,
  output logic preface_seen, blank_long, preface_mismatch, block_written, eot_marker, bot_marker
);
  // ----------------------------------------------------------------
  // head position in blocks and block spacing timer
  // ----------------------------------------------------------------
  logic [7:0] blk = 8'h00;
  logic [3:0] t = 4'h0;
  assign unit_ready = rdy;
  assign write_ring = ring;
  assign eot_block = eot_lvl;
  // events last one cycle, gap+1 apart, so the controller can stop between them
  always @(posedge clk) begin
    {preface_seen, blank_long, preface_mismatch, block_written, eot_marker, bot_marker} <= 6'h00;
    t <= (move_fwd | move_bwd) && t != gap ? t + 4'h1 : 4'h0;
    if ((move_fwd | move_bwd) && t == gap) begin
      if (move_bwd) begin
        preface_seen <= 1'b1;
        bot_marker <= mark && blk == 8'h01;
        blk <= blk - 8'h01;
      end else if (mark) begin
        eot_marker <= 1'b1;
      end else if (write_en) begin
        preface_mismatch <= mism;
        block_written <= !mism;
        blk <= blk + 8'h01;
      end else if (blk >= eoi) begin
        blank_long <= 1'b1; // past the last block only blank tape remains
      end else begin
        preface_seen <= 1'b1;
        blk <= blk + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// file: test/tape_position_interrogate_tb.sv
// self-checking bench of the tape positioning and interrogate block
`timescale 1ns/1ps
`default_nettype none
module tape_position_interrogate_tb;
  // ------
  // signals
  // ------
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, instr_valid = 1'b0, instr_ready, done, branch, halt;
  logic [3:0] instr_sign = 4'h0, instr_unit = 4'h0, instr_count = 4'h0, instr_var = 4'h0;
  logic [3:0] unit_sel, lane, s_axi_wstrb = 4'hf, gap = 4'h5;
  logic [7:0] instr_d34 = 8'h00, instr_op = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [7:0] eoi = 8'h0f;
  logic [15:0] instr_addr = 16'h0000, b_reg = 16'h0000, branch_addr;
  logic unit_ready, write_ring, preface_seen, blank_long, eot_block, preface_mismatch;
  logic block_written, eot_marker, bot_marker, move_fwd, move_bwd, write_en;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, rdy = 1'b1, ring = 1'b1, eot_lvl = 1'b0, mism = 1'b0, mark = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'hf124619d, rd, r;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  int error_cnt = 0, tests_run = 0, prf = 0, wrn = 0, blnk = 0, mv = 0;
  int bp = 0, bw = 0, bb = 0, bm = 0;
  logic [3:0] pv [3] = '{4'h0, 4'h9, 4'h1}, pn [3] = '{4'h3, 4'h0, 4'h2};
  int pe [3] = '{3, 10, 2}, pb [3] = '{3, 13, 11};
  logic [7:0] od [3] = '{8'h05, 8'h09, 8'h00};
  logic ori [3] = '{1'b1, 1'b1, 1'b0};
  logic [31:0] oc [3] = '{32'h4100, 32'h4100, 32'h4200};

  tpi_core u_dut (.*);
  tpi_tape_model u_tape (.*);

  always #10 clk = ~clk;
  // running event counts; each tape operation but the one hung at the end marker checks the growth since its issue
  always @(posedge clk) begin
    if (preface_seen) prf <= prf + 1;
    if (block_written) wrn <= wrn + 1;
    if (blank_long) blnk <= blnk + 1;
    if (move_fwd | move_bwd) mv <= mv + 1;
  end
  // ------
  // helpers
  // ------
  function automatic logic [31:0] nx();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw | w) begin
      @(posedge clk);
      if (s_axi_awready) begin aw = 1'b0; s_axi_awvalid <= 1'b0; end
      if (s_axi_wready) begin w = 1'b0; s_axi_wvalid <= 1'b0; end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, 2'b00);
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata; rr = s_axi_rresp; s_axi_rready <= 1'b0;
  endtask
  task automatic stq(input logic [31:0] m, input logic [31:0] e);
    axr(8'h04);
    chk(rd & m, e);
  endtask
  // operands are random; fields are held until the taking edge
  task automatic issue(input logic [7:0] op, input logic [3:0] v, n, input logic [7:0] d);
    r = nx();
    bp = prf; bw = wrn; bb = blnk; bm = mv;
    @(posedge clk);
    instr_op <= op; instr_var <= v; instr_count <= n; instr_d34 <= d; instr_unit <= r[23:20];
    instr_sign <= r[3:0]; instr_addr <= r[31:16]; b_reg <= r[19:4]; instr_valid <= 1'b1;
    gap <= 4'h5 + {2'b00, r[25:24]};
    @(posedge clk);
    instr_valid <= 1'b0;
  endtask
  task automatic wait_done(input int lim, output logic got);
    got = 1'b0;
    // look just after the taking edge first: interrogate done stands one cycle only
    for (int i = 0; i < lim && !got; i++) begin
      #1 got = (done === 1'b1);
      if (!got) @(posedge clk);
    end
  endtask
  // op code 8'h02 is the design's default interrogate code
  task automatic irg(input logic [3:0] v, input logic exp);
    logic g;
    issue(8'h02, v, 4'h0, 8'h00);
    wait_done(1, g);
    chk(g, 1'b1);
    chk(branch, exp);
    chk(unit_sel, instr_unit);
    chk(branch_addr, instr_sign[0] ? 16'(instr_addr + b_reg) : instr_addr);
  endtask
  // ------
  // scenarios
  // ------
  initial begin
    logic g;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    stq(32'hffffffff, 32'h00000001);
    axr(8'h0c);
    chk(rr, 2'b10);
    chk(rd, 32'h0);
    axw(8'h00, 32'h00000050);
    axr(8'h00);
    chk(rd & 32'hf0, 32'h50);
    chk(lane, 4'h5);
    irg(4'h1, 1'b0);
    for (int k = 0; k < 3; k++) begin
      issue(8'h58, pv[k], pn[k], 8'h00);
      wait_done(400, g);
      chk(g, 1'b1);
      chk(prf - bp, pe[k]);
      chk(u_tape.blk, pb[k]);
    end
    issue(8'h58, 4'h2, 4'h0, 8'h00);
    wait_done(400, g);
    chk({g, u_tape.blk[7:0]}, {1'b1, 8'h0e});
    chk(blnk - bb, 1);
    mark <= 1'b1;
    issue(8'h58, 4'h0, 4'h2, 8'h00);
    wait_done(80, g);
    chk(g, 1'b0);
    stq(32'h20ff, 32'h2040);
    irg(4'h0, 1'b0);
    mark <= 1'b0;
    axw(8'h00, 32'h00000051);
    stq(32'hffff, 32'h0001);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      ring <= ori[k];
      repeat (4) @(posedge clk);
      issue(8'h01, 4'h0, 4'h2, od[k]);
      repeat (10) @(posedge clk);
      chk(halt, 1'b1);
      chk(mv - bm, 0);
      chk(write_en, 1'b0);
      chk(instr_ready, 1'b0);
      stq(32'h4f00, oc[k]);
      axw(8'h00, 32'h00000051);
    end
    ring <= 1'b1;
    eot_lvl <= 1'b1;
    repeat (4) @(posedge clk);
    issue(8'h01, 4'h0, 4'h2, 8'h01);
    wait_done(400, g);
    chk({g, 8'(wrn - bw)}, {1'b1, 8'h02});
    mism <= 1'b1;
    issue(8'h01, 4'h0, 4'h3, 8'h00);
    wait_done(400, g);
    chk({g, 8'(wrn - bw)}, {1'b1, 8'h00});
    stq(32'h1000, 32'h1000);
    mism <= 1'b0;
    // eot indicator now set: variation 1 must branch whatever the unit says
    repeat (12) begin
      r = nx();
      @(posedge clk);
      rdy <= r[8];
      repeat (5) @(posedge clk);
      irg(r[0] ? 4'h1 : r[7:4], r[0] | r[7:4] == 4'h1 ? 1'b1 : r[8]);
    end
    tally_and_finish();
  end
  // whole run needs well under a thousand cycles; this bound only cuts a hang
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
